// ---- design/vplt_pkg.sv ----
package vplt_pkg;

  // Word layout: bit 31 is the entry-valid flag, value fields sit at bit 0
  localparam int VALID_BIT = 31;
  localparam int PROTO_W   = 8;
  localparam int ETYPE_W   = 16;
  localparam int VID_W     = 12;
  localparam int SLOT_W    = 8;
  localparam int N_CUSTOM  = 3;
  localparam int VID_DEPTH  = 4096;
  localparam int SLOT_DEPTH = 256;

  // Register map, byte addresses of instance 0 and instance 5
  localparam int          ADDR_W        = 19;
  localparam logic [18:0] V2S_LO_BASE   = 19'h48000;
  localparam logic [18:0] S2V_LO_BASE   = 19'h4d000;
  localparam logic [18:0] IP_LO_BASE    = 19'h4dfc0;
  localparam logic [18:0] ET_LO_BASE    = 19'h4dfd0;
  localparam logic [18:0] V2S_HI_BASE   = 19'h70000;
  localparam logic [18:0] S2V_HI_BASE   = 19'h75000;
  localparam logic [18:0] IP_HI_BASE    = 19'h75fc0;
  localparam logic [18:0] ET_HI_BASE    = 19'h75fd0;
  localparam logic [18:0] INST_SPACING  = 19'h08000;
  localparam int          LO_INSTANCES  = 5;
  localparam logic [18:0] V2S_BYTES     = 19'h04000;
  localparam logic [18:0] S2V_BYTES     = 19'h00400;
  localparam logic [18:0] CUSTOM_BYTES  = 19'h0000c;

  // Reset values
  localparam logic [PROTO_W-1:0] PROTO_RST = 8'h00;
  localparam logic [ETYPE_W-1:0] ETYPE_RST = 16'h0000;
  localparam logic [31:0]        RDATA_RST = 32'h0000_0000;

  // Custom type codes
  localparam logic [1:0] CODE_TYPE0 = 2'h0;
  localparam logic [1:0] CODE_TYPE1 = 2'h1;
  localparam logic [1:0] CODE_TYPE2 = 2'h2;

  function automatic logic [18:0] vplt_inst_base(input logic [18:0] lo, input logic [18:0] hi, input int inst);
    if (inst < LO_INSTANCES) begin
      return lo + 19'(inst) * INST_SPACING;
    end
    return hi + 19'(inst - LO_INSTANCES) * INST_SPACING;
  endfunction

endpackage

// ---- design/vplt_match.sv ----
`timescale 1ns/1ps
module vplt_match #(
  parameter int W = 8
) (
  input  wire logic         en_i,
  input  wire logic [W-1:0] rec_i,
  input  wire logic [W-1:0] key_i,
  output logic              hit_o
);
  // A record with its flag clear never hits
  assign hit_o = en_i && (rec_i == key_i);
endmodule

// ---- design/vplt_top.sv ----
// What this block does
// - Only flagged custom records take part matching
// - IP protocol match gives type code 0-2
// - Ethertype match gives type code 0-2
// - Ingress packet gets one 8-bit slot only if its identifier record is flagged
// - Egress slot converts back to 12-bit identifier
// - Identifier addresses 4096-record table, returns slot
// - Identifier width: full 12 bits used
// - Invalid slot is never passed on usable
// - Every identifier value is accepted for lookup
`timescale 1ns/1ps
module vplt_top import vplt_pkg::*; #(
  parameter int INST = 0
) (
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                arst_n_i,
  // Supervisor register port
  input  wire logic [ADDR_W-1:0]   reg_addr_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire logic [31:0]         reg_wdata_i,
  output logic      [31:0]         reg_rdata_o,
  output logic                     reg_rd_ack_o,
  // Ingress protocol classification
  input  wire logic                cls_req_i,
  input  wire logic [PROTO_W-1:0]  ip_proto_i,
  input  wire logic [ETYPE_W-1:0]  ethertype_i,
  output logic                     cls_ack_o,
  output logic                     ip_hit_o,
  output logic      [1:0]          ip_code_o,
  output logic                     et_hit_o,
  output logic      [1:0]          et_code_o,
  // Ingress identifier to slot
  input  wire logic                vid_req_i,
  input  wire logic [VID_W-1:0]    tag_identifier_value_i,
  output logic                     slot_ack_o,
  output logic                     slot_valid_o,
  output logic      [SLOT_W-1:0]   slot_o,
  // Egress slot to identifier
  input  wire logic                egr_req_i,
  input  wire logic [SLOT_W-1:0]   egr_slot_i,
  output logic                     egr_ack_o,
  output logic      [VID_W-1:0]    tag_identifier_value_o
);

  localparam logic [18:0] B_V2S = vplt_inst_base(V2S_LO_BASE, V2S_HI_BASE, INST);
  localparam logic [18:0] B_S2V = vplt_inst_base(S2V_LO_BASE, S2V_HI_BASE, INST);
  localparam logic [18:0] B_IP  = vplt_inst_base(IP_LO_BASE, IP_HI_BASE, INST);
  localparam logic [18:0] B_ET  = vplt_inst_base(ET_LO_BASE, ET_HI_BASE, INST);
  typedef struct packed {
    logic                              init_busy;
    logic [VID_W-1:0]                  init_idx;
    logic [N_CUSTOM-1:0]               ip_en;
    logic [N_CUSTOM-1:0][PROTO_W-1:0]  ip_val;
    logic [N_CUSTOM-1:0]               et_en;
    logic [N_CUSTOM-1:0][ETYPE_W-1:0]  et_val;
    logic                              cls_ack;
    logic                              ip_hit;
    logic [1:0]                        ip_code;
    logic                              et_hit;
    logic [1:0]                        et_code;
    logic                              slot_ack;
    logic                              slot_vld;
    logic [SLOT_W-1:0]                 slot;
    logic                              egr_ack;
    logic [VID_W-1:0]                  vid;
    logic                              rd_ack;
    logic [31:0]                       rdata;
  } vplt_state_t;
  vplt_state_t q, d;
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  // Valid flag in bit SLOT_W, slot number below it
  logic [SLOT_W:0]  v2s_mem [VID_DEPTH];
  logic [VID_W-1:0] s2v_mem [SLOT_DEPTH];
  logic [N_CUSTOM-1:0] ip_match;
  logic [N_CUSTOM-1:0] et_match;
  logic [18:0]         off_v2s;
  logic [18:0]         off_s2v;
  logic [18:0]         off_ip;
  logic [18:0]         off_et;
  logic                sel_v2s;
  logic                sel_s2v;
  logic                sel_ip;
  logic                sel_et;
  logic [1:0]          rec_ip;
  logic [1:0]          rec_et;
  logic                v2s_we;
  logic [VID_W-1:0]    v2s_waddr;
  logic [SLOT_W:0]     v2s_wdata;
  logic                s2v_we;
  logic [SLOT_W-1:0]   s2v_waddr;
  logic [VID_W-1:0]    s2v_wdata;
  logic [SLOT_W:0]     v2s_rd;
  logic [VID_W-1:0]    s2v_rd;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];
  genvar g;
  generate
    for (g = 0; g < N_CUSTOM; g++) begin : g_rec
      vplt_match #(.W(PROTO_W)) u_ip (
        .en_i  (q.ip_en[g]),
        .rec_i (q.ip_val[g]),
        .key_i (ip_proto_i),
        .hit_o (ip_match[g])
      );
      vplt_match #(.W(ETYPE_W)) u_et (
        .en_i  (q.et_en[g]),
        .rec_i (q.et_val[g]),
        .key_i (ethertype_i),
        .hit_o (et_match[g])
      );
    end
  endgenerate

  // Address decode: windows relative to this instance's bases
  assign off_v2s = reg_addr_i - B_V2S;
  assign off_s2v = reg_addr_i - B_S2V;
  assign off_ip  = reg_addr_i - B_IP;
  assign off_et  = reg_addr_i - B_ET;
  assign sel_v2s = (reg_addr_i >= B_V2S) && (off_v2s < V2S_BYTES);
  assign sel_s2v = (reg_addr_i >= B_S2V) && (off_s2v < S2V_BYTES);
  assign sel_ip  = (reg_addr_i >= B_IP) && (off_ip < CUSTOM_BYTES);
  assign sel_et  = (reg_addr_i >= B_ET) && (off_et < CUSTOM_BYTES);
  assign rec_ip  = off_ip[3:2];
  assign rec_et  = off_et[3:2];
  // Table reads are asynchronous, the answer is registered once
  assign v2s_rd = v2s_mem[tag_identifier_value_i];
  assign s2v_rd = s2v_mem[egr_slot_i];
  // Init sweep clears both tables so no stale valid flag survives reset
  always_comb begin
    v2s_we    = 1'b0;
    v2s_waddr = off_v2s[13:2];
    v2s_wdata = {reg_wdata_i[VALID_BIT], reg_wdata_i[SLOT_W-1:0]};
    s2v_we    = 1'b0;
    s2v_waddr = off_s2v[9:2];
    s2v_wdata = reg_wdata_i[VID_W-1:0];
    if (q.init_busy) begin
      v2s_we    = 1'b1;
      v2s_waddr = q.init_idx;
      v2s_wdata = '0;
      s2v_we    = 1'b1;
      s2v_waddr = q.init_idx[SLOT_W-1:0];
      s2v_wdata = '0;
    end else if (reg_wr_i) begin
      v2s_we = sel_v2s;
      s2v_we = sel_s2v;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (v2s_we) begin
      v2s_mem[v2s_waddr] <= v2s_wdata;
    end
    if (s2v_we) begin
      s2v_mem[s2v_waddr] <= s2v_wdata;
    end
  end

  always_comb begin
    d          = q;
    d.cls_ack  = cls_req_i;
    d.slot_ack = vid_req_i;
    d.egr_ack  = egr_req_i;
    d.rd_ack   = reg_rd_i;
    if (q.init_busy) begin
      d.init_idx  = q.init_idx + 12'h001;
      d.init_busy = (q.init_idx != 12'hfff);
    end
    if (cls_req_i) begin
      d.ip_hit  = |ip_match;
      d.ip_code = ip_match[0] ? CODE_TYPE0 : (ip_match[1] ? CODE_TYPE1 : CODE_TYPE2);
      d.et_hit  = |et_match;
      d.et_code = et_match[0] ? CODE_TYPE0 : (et_match[1] ? CODE_TYPE1 : CODE_TYPE2);
    end
    if (vid_req_i) begin
      // Slot is forced to zero when the flag is clear
      d.slot_vld = v2s_rd[SLOT_W] && !q.init_busy;
      d.slot     = d.slot_vld ? v2s_rd[SLOT_W-1:0] : '0;
    end
    if (egr_req_i) begin
      d.vid = s2v_rd;
    end
    if (reg_wr_i && sel_ip && rec_ip < 2'(N_CUSTOM)) begin
      d.ip_en[rec_ip]  = reg_wdata_i[VALID_BIT];
      d.ip_val[rec_ip] = reg_wdata_i[PROTO_W-1:0];
    end
    if (reg_wr_i && sel_et && rec_et < 2'(N_CUSTOM)) begin
      d.et_en[rec_et]  = reg_wdata_i[VALID_BIT];
      d.et_val[rec_et] = reg_wdata_i[ETYPE_W-1:0];
    end
    if (reg_rd_i) begin
      d.rdata = RDATA_RST;
      if (sel_v2s) begin
        d.rdata[VALID_BIT]    = v2s_mem[off_v2s[13:2]][SLOT_W];
        d.rdata[SLOT_W-1:0]   = v2s_mem[off_v2s[13:2]][SLOT_W-1:0];
      end else if (sel_s2v) begin
        d.rdata[VID_W-1:0]    = s2v_mem[off_s2v[9:2]];
      end else if (sel_ip && rec_ip < 2'(N_CUSTOM)) begin
        d.rdata[VALID_BIT]    = q.ip_en[rec_ip];
        d.rdata[PROTO_W-1:0]  = q.ip_val[rec_ip];
      end else if (sel_et && rec_et < 2'(N_CUSTOM)) begin
        d.rdata[VALID_BIT]    = q.et_en[rec_et];
        d.rdata[ETYPE_W-1:0]  = q.et_val[rec_et];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      q           <= '0;
      q.init_busy <= 1'b1;
      q.ip_val    <= {N_CUSTOM{PROTO_RST}};
      q.et_val    <= {N_CUSTOM{ETYPE_RST}};
      q.rdata     <= RDATA_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o            = q.rdata;
  assign reg_rd_ack_o           = q.rd_ack;
  assign cls_ack_o              = q.cls_ack;
  assign ip_hit_o               = q.ip_hit;
  assign ip_code_o              = q.ip_code;
  assign et_hit_o               = q.et_hit;
  assign et_code_o              = q.et_code;
  assign slot_ack_o             = q.slot_ack;
  assign slot_valid_o           = q.slot_vld;
  assign slot_o                 = q.slot;
  assign egr_ack_o              = q.egr_ack;
  assign tag_identifier_value_o = q.vid;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);
  sequence s_ip0_match;
    cls_req_i && q.ip_en[0] && (ip_proto_i == q.ip_val[0]);
  endsequence
  sequence s_et1_only;
    cls_req_i && !et_match[0] && q.et_en[1] && (ethertype_i == q.et_val[1]);
  endsequence
  sequence s_vid_answer;
    ##1 slot_ack_o && (slot_valid_o == $past(v2s_rd[SLOT_W]));
  endsequence
  // Write, one idle cycle, then a read of the same record
  sequence s_ip2_write_then_read;
    reg_wr_i && sel_ip && (rec_ip == 2'h2) ##1 !reg_wr_i ##1 reg_rd_i && sel_ip && (rec_ip == 2'h2) && !reg_wr_i;
  endsequence
  property p_ip_off_no_hit;
    cls_req_i && (q.ip_en == 3'h0) |=> cls_ack_o && !ip_hit_o;
  endproperty
  a_ip_off_no_hit: assert property (p_ip_off_no_hit) else $error("disabled ip record hit");
  property p_et_off_no_hit;
    cls_req_i && (q.et_en == 3'h0) |=> !et_hit_o;
  endproperty
  a_et_off_no_hit: assert property (p_et_off_no_hit) else $error("disabled etype record hit");
  property p_ip_code0;
    s_ip0_match |=> ip_hit_o && (ip_code_o == 2'h0);
  endproperty
  a_ip_code0: assert property (p_ip_code0) else $error("ip record 0 not coded 0");
  property p_et_code1;
    s_et1_only |=> et_hit_o && (et_code_o == 2'h1);
  endproperty
  a_et_code1: assert property (p_et_code1) else $error("etype record 1 not coded 1");
  property p_vid_lookup;
    vid_req_i && !q.init_busy |-> s_vid_answer;
  endproperty
  a_vid_lookup: assert property (p_vid_lookup) else $error("slot answer wrong");
  property p_slot_invalid_zero;
    slot_ack_o && !slot_valid_o |-> (slot_o == 8'h00);
  endproperty
  a_slot_invalid_zero: assert property (p_slot_invalid_zero) else $error("invalid slot not zero");
  property p_egr_vid;
    egr_req_i |=> egr_ack_o && (tag_identifier_value_o == $past(s2v_rd));
  endproperty
  a_egr_vid: assert property (p_egr_vid) else $error("egress identifier wrong");
  property p_top_vid;
    vid_req_i && !q.init_busy && (tag_identifier_value_i == 12'hfff) |=>
      slot_valid_o == $past(v2s_mem[4095][SLOT_W]);
  endproperty
  a_top_vid: assert property (p_top_vid) else $error("top identifier refused");
  property p_ip_readback;
    s_ip2_write_then_read |=> reg_rd_ack_o && (reg_rdata_o[31] == $past(reg_wdata_i[31], 3))
      && (reg_rdata_o[7:0] == $past(reg_wdata_i[7:0], 3));
  endproperty
  a_ip_readback: assert property (p_ip_readback) else $error("ip record readback mismatch");
endmodule

// ---- bench/vplt_sup.sv ----
`timescale 1ns/1ps
// Supervisor side; flagged identifier-table writes past the first SLOT_DEPTH lose their flag
module vplt_sup import vplt_pkg::*; (
  // Clock
  input  wire logic              clk_sys_i,
  // Register port
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   wr_o,
  output logic                   rd_o,
  output logic      [31:0]       wdata_o,
  input  wire logic [31:0]       rdata_i,
  input  wire logic              rd_ack_i
);
  int n_valid = 0;

  initial begin
    addr_o  = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = '0;
  end

  task automatic wr(input logic [18:0] a, input logic [31:0] d);
    if (d[VALID_BIT] && a >= V2S_LO_BASE && a < V2S_LO_BASE + V2S_BYTES) begin
      n_valid++;
    end
    if (n_valid > SLOT_DEPTH) begin
      d[VALID_BIT] = 1'b0;
    end
    @(posedge clk_sys_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_sys_i);
    wr_o    <= 1'b0;
    // Released lines flip so a stale value never passes for a live one
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask

  task automatic rd(input logic [18:0] a, output logic [31:0] d, output bit ok);
    ok = 1'b0;
    d  = '0;
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_sys_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    // Ack stands one cycle from the taking edge, so look just after each edge
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (rd_ack_i === 1'b1) begin
        ok = 1'b1;
        d  = rdata_i;
      end else begin
        @(posedge clk_sys_i);
      end
    end
  endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench import vplt_pkg::*; ;
  logic              clk_sys_i, arst_n_i, wr, rd, rd_ack, cls_req, cls_ack, ip_hit, et_hit;
  logic              vid_req, slot_ack, slot_vld, egr_req, egr_ack;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata, rdata, k;
  logic [7:0]        proto, slot, egr_slot, pk, s;
  logic [15:0]       etype, ek;
  logic [11:0]       vid, egr_vid, id;
  logic [1:0]        ip_code, et_code;
  logic [2:0]        e;
  logic [8:0]        e9;
  logic [31:0]       ip_rec [3];
  logic [31:0]       et_rec [3];
  logic [8:0]        v2s [int];
  logic [11:0]       s2v [int];
  logic [11:0]       ids [$];
  logic [7:0]        sl [$];
  int                n_mismatch = 0;
  int                n_tests = 0;
  int                seed = 2046;

  vplt_top dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rd_ack_o(rd_ack), .cls_req_i(cls_req), .ip_proto_i(proto),
    .ethertype_i(etype), .cls_ack_o(cls_ack), .ip_hit_o(ip_hit), .ip_code_o(ip_code), .et_hit_o(et_hit),
    .et_code_o(et_code), .vid_req_i(vid_req), .tag_identifier_value_i(vid), .slot_ack_o(slot_ack),
    .slot_valid_o(slot_vld), .slot_o(slot), .egr_req_i(egr_req), .egr_slot_i(egr_slot), .egr_ack_o(egr_ack),
    .tag_identifier_value_o(egr_vid));
  vplt_sup u_sup (.clk_sys_i(clk_sys_i), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
    .rdata_i(rdata), .rd_ack_i(rd_ack));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic rdchk(input string nm, input logic [18:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bit          ok;
    u_sup.rd(a, d, ok);
    chk("read ack", ok, 1'b1);
    chk(nm, d, exp);
    if (!ok) begin
      report_and_stop();
    end
  endtask

  // Kind 0 classify, 1 ingress lookup, 2 egress lookup
  task automatic lookup(input int kind, input logic [15:0] ka, input logic [7:0] kb);
    bit got;
    got = 1'b0;
    @(posedge clk_sys_i);
    cls_req  <= (kind == 0);
    vid_req  <= (kind == 1);
    egr_req  <= (kind == 2);
    etype    <= ka;
    vid      <= ka[11:0];
    proto    <= kb;
    egr_slot <= kb;
    @(posedge clk_sys_i);
    {cls_req, vid_req, egr_req} <= 3'b000;
    etype    <= ~ka;
    vid      <= ~ka[11:0];
    proto    <= ~kb;
    egr_slot <= ~kb;
    // Ack stands one cycle from the taking edge, so look just after each edge
    for (int i = 0; i < 4 && !got; i++) begin
      #1;
      got = (kind == 0) ? cls_ack === 1'b1 : (kind == 1) ? slot_ack === 1'b1 : egr_ack === 1'b1;
      if (!got) begin
        @(posedge clk_sys_i);
      end
    end
    if (!got) begin
      chk("lookup ack", 1'b0, 1'b1);
      report_and_stop();
    end
  endtask

  // Lowest flagged record with an equal value wins
  function automatic logic [2:0] exp_code(input logic [31:0] rec [3], input logic [15:0] key,
                                          input logic [15:0] msk);
    for (int r = 0; r < N_CUSTOM; r++) begin
      if (rec[r][VALID_BIT] && ((rec[r][15:0] & msk) == key)) begin
        return {1'b1, 2'(r)};
      end
    end
    return 3'b000;
  endfunction

  initial begin
    arst_n_i = 1'b0;
    {cls_req, vid_req, egr_req} = 3'b000;
    {etype, vid, proto, egr_slot} = '0;
    repeat (16) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    // Table clear sweep must finish before table traffic
    repeat (4200) @(posedge clk_sys_i);
    u_sup.wr(IP_LO_BASE + 19'h8, 32'hffff_ffff);
    rdchk("ip unused bits", IP_LO_BASE + 19'h8, 32'h8000_00ff);
    rdchk("unmapped", IP_LO_BASE + 19'hc, 32'h0);
    for (int rnd = 0; rnd < 6; rnd++) begin
      for (int r = 0; r < N_CUSTOM; r++) begin
        k = $random(seed);
        // Round 0 repeats one value in every record, round 5 clears every flag
        ip_rec[r] = {(k[31] && rnd != 5) || rnd == 0, 23'h0, (rnd == 0) ? 8'h11 : k[7:0]};
        et_rec[r] = {(k[30] && rnd != 5) || rnd == 0, 15'h0, (rnd == 0) ? 16'h88b5 : k[23:8]};
        u_sup.wr(IP_LO_BASE + 19'(4 * r), ip_rec[r]);
        u_sup.wr(ET_LO_BASE + 19'(4 * r), et_rec[r]);
        rdchk("ip rec", IP_LO_BASE + 19'(4 * r), ip_rec[r]);
        rdchk("et rec", ET_LO_BASE + 19'(4 * r), et_rec[r]);
      end
      for (int i = 0; i < 20; i++) begin
        k = $random(seed);
        pk = k[0] ? ip_rec[k[2:1] % 3][7:0] : k[15:8];
        ek = k[3] ? et_rec[k[5:4] % 3][15:0] : k[31:16];
        lookup(0, ek, pk);
        e = exp_code(ip_rec, {8'h00, pk}, 16'h00ff);
        chk("ip hit", ip_hit, e[2]);
        if (e[2]) chk("ip code", ip_code, e[1:0]);
        e = exp_code(et_rec, ek, 16'hffff);
        chk("et hit", et_hit, e[2]);
        if (e[2]) chk("et code", et_code, e[1:0]);
      end
    end
    // Corners 000, 7ff, 800, fff expose an identifier cut to 11 bits
    for (int i = 0; i < 40; i++) begin
      k = $random(seed);
      id = (i < 4) ? {i[1], {11{i[0]}}} : k[11:0];
      v2s[id] = {k[31] | (i < 4), k[19:12]};
      ids.push_back(id);
      u_sup.wr(V2S_LO_BASE + 19'({id, 2'b00}), {v2s[id][8], 23'h0, v2s[id][7:0]});
    end
    rdchk("v2s rec", V2S_LO_BASE + 19'h2000, {v2s[12'h800][8], 23'h0, v2s[12'h800][7:0]});
    for (int i = 0; i < 80; i++) begin
      k = $random(seed);
      id = (i < 40) ? ids[i] : k[11:0];
      e9 = v2s.exists(id) ? v2s[id] : 9'h000;
      lookup(1, {4'h0, id}, 8'h00);
      chk("slot valid", slot_vld, e9[8]);
      chk("slot", slot, e9[8] ? e9[7:0] : 8'h00);
    end
    for (int i = 0; i < 30; i++) begin
      k = $random(seed);
      s = (i < 2) ? {8{i[0]}} : k[7:0];
      s2v[s] = k[27:16];
      sl.push_back(s);
      u_sup.wr(S2V_LO_BASE + 19'({s, 2'b00}), {20'h0, k[27:16]});
    end
    rdchk("s2v rec", S2V_LO_BASE + 19'h3fc, {20'h0, s2v[255]});
    foreach (sl[i]) begin
      lookup(2, 16'h0, sl[i]);
      chk("egress id", egr_vid, s2v[sl[i]]);
    end
    report_and_stop();
  end
endmodule
